// ===== src/cvlc_top.sv
// ------------------------------------------------------------------
// Coil voltage limit check: two thresholds and their status flags
// ------------------------------------------------------------------

module cvlc_top
  import cvlc_pkg::*;
(
  input  wire logic                        mclk_in,
  input  wire logic                        nrst_in,
  input  wire logic                        ce_in,
  input  wire logic [cvlc_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  input  wire logic [cvlc_pkg::WORD_W-1:0] reg_wdata_in,
  input  wire logic [cvlc_pkg::SAMPLE_W-1:0] averaged_coil_sample_in,
  input  wire logic                        sample_valid_in,
  output logic [cvlc_pkg::WORD_W-1:0]      reg_rdata_out,
  output logic                             reg_rvalid_out,
  output logic                             reg_hit_out,
  output logic [cvlc_pkg::SAMPLE_W-1:0]    low_threshold_a_out,
  output logic [cvlc_pkg::SAMPLE_W-1:0]    high_threshold_out,
  output logic                             below_low_a_flag_out,
  output logic                             above_high_flag_out
);

  import cvlc_pkg::*;

  // Everything here runs on the one clock; the register strobes and the
  // sample inputs come from logic on that clock, so none is synchronised.

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Odd parity over the upper fifteen bits, placed in bit 0 on reads
  // Write parity is not checked: a bad parity bit from the host is
  // ignored rather than rejected, a trade of safety for simplicity.
  function automatic logic odd_parity(input logic [WORD_W-1:1] bits);
    odd_parity = ~(^bits);
  endfunction

  // Build a readable word from a threshold: reserved bits zero
  function automatic logic [WORD_W-1:0] pack_word(input logic [SAMPLE_W-1:0] thr);
    logic [WORD_W-1:0] w;
    w = WORD_ZERO;
    w[THR_MSB:THR_LSB] = thr;
    w[PARITY_BIT] = odd_parity(w[WORD_W-1:1]);
    pack_word = w;
  endfunction

  // Offset decode, shared by the write side and the read side so that
  // both always agree on which offsets are mapped
  function automatic logic is_low_a(input logic [ADDR_W-1:0] addr);
    is_low_a = (addr == LOW_LIMIT_A_ADDR);
  endfunction

  function automatic logic is_upper(input logic [ADDR_W-1:0] addr);
    is_upper = (addr == UPPER_LIMIT_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // Threshold registers
  // ----------------------------------------------------------------
  // Both thresholds are ten bits wide and sit in bits 10:1 of a
  // sixteen-bit word. Software may write any value to the reserved
  // bits or to the parity position; they are simply not stored, so a
  // read always returns zeros there and a freshly computed parity.
  // A write is taken on a rising edge with the clock enable high and
  // shows on the threshold outputs one cycle later. Writes to offsets
  // that are not mapped leave both thresholds untouched.
  logic [SAMPLE_W-1:0] low_a_d;
  logic [SAMPLE_W-1:0] low_a_q;
  logic [SAMPLE_W-1:0] upper_d;
  logic [SAMPLE_W-1:0] upper_q;

  // Writes take only bits 10:1; reserved bits and parity are dropped
  always_comb
  begin
    low_a_d = low_a_q;
    upper_d = upper_q;
    if (reg_wr_in)
    begin
      if (is_low_a(reg_addr_in))
      begin
        low_a_d = reg_wdata_in[THR_MSB:THR_LSB];
      end
      if (is_upper(reg_addr_in))
      begin
        upper_d = reg_wdata_in[THR_MSB:THR_LSB];
      end
    end
  end

  // Upper resets high so nothing trips it before software sets it
  // A low clock enable freezes every register of the block.
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      low_a_q <= LOW_A_RESET;
      upper_q <= UPPER_RESET;
    end
    else if (ce_in)
    begin
      low_a_q <= low_a_d;
      upper_q <= upper_d;
    end
  end

  assign low_threshold_a_out = low_a_q;
  assign high_threshold_out  = upper_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // The answer is registered so the read data comes straight from a
  // flip-flop. The valid pulse lasts one cycle; data and hit hold until
  // the next read, which lets a slow host pick them up later.
  // A read and a write to the same offset in one cycle return the value
  // from before the write.
  logic [WORD_W-1:0] rdata_d;
  logic [WORD_W-1:0] rdata_q;
  logic              rvalid_d;
  logic              rvalid_q;
  logic              hit_d;
  logic              hit_q;

  // Registered answer one cycle after the read; unmapped reads give zero
  always_comb
  begin
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    hit_d    = hit_q;
    if (reg_rd_in)
    begin
      rvalid_d = 1'b1;
      hit_d    = 1'b1;
      if (is_low_a(reg_addr_in))
      begin
        rdata_d = pack_word(low_a_q);
      end
      else if (is_upper(reg_addr_in))
      begin
        rdata_d = pack_word(upper_q);
      end
      else
      begin
        // Unmapped offset answers zero so a wrong address is visible
        rdata_d = WORD_ZERO;
        hit_d   = 1'b0;
      end
    end
  end

  // Answer registers, frozen like all state while the clock enable is low
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rdata_q  <= WORD_ZERO;
      rvalid_q <= 1'b0;
      hit_q    <= 1'b0;
    end
    else if (ce_in)
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      hit_q    <= hit_d;
    end
  end

  assign reg_rdata_out  = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign reg_hit_out    = hit_q;

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // The sample is compared against the thresholds as they stand in the
  // same cycle, so a write and a sample together use the old threshold.
  // Equal values clear both flags: the low check is strictly below and
  // the upper check strictly above. Each flag only moves on a valid
  // sample, so a host may read the flags at any time between samples
  // and sees the verdict on the latest sample taken with the clock enable high.

  cvlc_limit_flag u_low_a (
    .mclk_in         (mclk_in),
    .nrst_in         (nrst_in),
    .ce_in           (ce_in),
    .dir_in          (CVLC_BELOW),
    .threshold_in    (low_a_q),
    .sample_in       (averaged_coil_sample_in),
    .sample_valid_in (sample_valid_in),
    .flag_out        (below_low_a_flag_out)
  );

  cvlc_limit_flag u_upper (
    .mclk_in         (mclk_in),
    .nrst_in         (nrst_in),
    .ce_in           (ce_in),
    .dir_in          (CVLC_ABOVE),
    .threshold_in    (upper_q),
    .sample_in       (averaged_coil_sample_in),
    .sample_valid_in (sample_valid_in),
    .flag_out        (above_high_flag_out)
  );

endmodule

// ===== src/cvlc_pkg.sv
package cvlc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned SAMPLE_W  = 10;

  localparam logic [ADDR_W-1:0] LOW_LIMIT_A_ADDR = 8'h0e;
  localparam logic [ADDR_W-1:0] UPPER_LIMIT_ADDR = 8'h0f;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int unsigned THR_LSB    = 1;
  localparam int unsigned THR_MSB    = 10;
  localparam int unsigned PARITY_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SAMPLE_W-1:0] LOW_A_RESET = 10'h000;
  localparam logic [SAMPLE_W-1:0] UPPER_RESET = 10'h3ff;
  localparam logic [WORD_W-1:0]   WORD_ZERO   = 16'h0000;

  // Direction of a threshold comparison
  typedef enum logic {
    CVLC_BELOW,
    CVLC_ABOVE
  } cvlc_dir_t;

endpackage

// ===== src/cvlc_limit_flag.sv
// ------------------------------------------------------------------
// One threshold comparator with its held flag
// ------------------------------------------------------------------
module cvlc_limit_flag
  import cvlc_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                nrst_in,
  input  wire logic                ce_in,
  input  wire cvlc_dir_t           dir_in,
  input  wire logic [SAMPLE_W-1:0] threshold_in,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  input  wire logic                sample_valid_in,
  output logic                     flag_out
);

  logic flag_d;
  logic flag_q;
  logic hit;

  // Unsigned compare in the chosen direction
  // unsigned compare
  always_comb
  begin
    if (dir_in == CVLC_ABOVE)
    begin
      hit = (sample_in > threshold_in);
    end
    else
    begin
      hit = (sample_in < threshold_in);
    end
  end

  // Flag follows each fresh sample and holds between samples
  // update on valid
  always_comb
  begin
    flag_d = flag_q;
    if (sample_valid_in)
    begin
      flag_d = hit;
    end
  end

  // Flag register; cleared by reset so no limit looks violated early
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      flag_q <= 1'b0;
    end
    else if (ce_in)
    begin
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q;

endmodule

// ===== bench/cvlc_assertions.sv
// ------------------------------------------------------------
// Coil voltage limit checker
// ------------------------------------------------------------
module cvlc_assertions
  import cvlc_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        nrst_in,
  input wire logic        ce_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [9:0]  averaged_coil_sample_in,
  input wire logic        sample_valid_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        reg_rvalid_out,
  input wire logic        reg_hit_out,
  input wire logic [9:0]  low_threshold_a_out,
  input wire logic [9:0]  high_threshold_out,
  input wire logic        below_low_a_flag_out,
  input wire logic        above_high_flag_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Requests only count while the clock enable is high
  logic       rd_go, wr_go, sv_go;
  logic [9:0] wthr;
  assign rd_go = ce_in & reg_rd_in;
  assign wr_go = ce_in & reg_wr_in;
  assign sv_go = ce_in & sample_valid_in;
  assign wthr  = reg_wdata_in[10:1];
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  AST_RD_ANSWER: assert property (rd_go |=> reg_rvalid_out)
    else $error("read not answered");
  AST_RD_QUIET: assert property (ce_in && !reg_rd_in |=> !reg_rvalid_out)
    else $error("answer without read");
  AST_FREEZE: assert property (!ce_in |=> $stable(reg_rvalid_out)
    && $stable(reg_rdata_out) && $stable(low_threshold_a_out) && $stable(high_threshold_out))
    else $error("state moved while frozen");
  AST_RSV_ZERO: assert property (reg_rvalid_out |-> reg_rdata_out[15:11] == 5'h00)
    else $error("reserved bits not zero");
  AST_PARITY: assert property (reg_rvalid_out && reg_hit_out |-> ^reg_rdata_out)
    else $error("read word parity even");
  AST_LOW_WR: assert property (wr_go && reg_addr_in == LOW_LIMIT_A_ADDR
    |=> low_threshold_a_out == $past(wthr)) else $error("low threshold not stored");
  AST_HIGH_WR: assert property (wr_go && reg_addr_in == UPPER_LIMIT_ADDR
    |=> high_threshold_out == $past(wthr)) else $error("upper threshold not stored");
  AST_BELOW: assert property (sv_go |=> below_low_a_flag_out ==
    ($past(averaged_coil_sample_in) < $past(low_threshold_a_out))) else $error("below flag");
  AST_ABOVE: assert property (sv_go |=> above_high_flag_out ==
    ($past(averaged_coil_sample_in) > $past(high_threshold_out))) else $error("above flag");
  AST_HOLD: assert property (!sv_go |=> $stable(below_low_a_flag_out)
    && $stable(above_high_flag_out)) else $error("flag moved without sample");
  // Main scenarios reached
  cover property (sv_go && averaged_coil_sample_in < low_threshold_a_out);
  cover property (sv_go && averaged_coil_sample_in > high_threshold_out);
  cover property (rd_go && reg_addr_in == UPPER_LIMIT_ADDR);
endmodule

// ===== bench/cvlc_host.sv
// ------------------------------------------------------------
// Host side of the register port
// ------------------------------------------------------------
module cvlc_host
  import cvlc_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  input  wire logic        hit_in,
  output logic [7:0]       addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic [15:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'h0000;
  end
  // Data is inverted after the strobe so a stale word never looks fresh
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge mclk_in);
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask
  // Answer comes one cycle after the strobe is taken
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d, output logic h, v);
    @(negedge mclk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge mclk_in);
    rd_out = 1'b0;
    d = rdata_in;
    h = hit_in;
    v = rvalid_in;
  endtask
endmodule

// ===== bench/coil_voltage_limit_check_bench.sv
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
module coil_voltage_limit_check_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import cvlc_pkg::*;
  logic        mclk_in, nrst_in, ce_in, reg_wr_in, reg_rd_in, sample_valid_in;
  logic        reg_rvalid_out, reg_hit_out, below_low_a_flag_out, above_high_flag_out;
  logic [7:0]  reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out;
  logic [9:0]  averaged_coil_sample_in, low_threshold_a_out, high_threshold_out;
  int          error_cnt = 0;
  int          cmp_count = 0;
  logic [9:0]  smpl [6] = '{10'h0ff, 10'h100, 10'h200, 10'h201, 10'h3ff, 10'h000};
  cvlc_top cvlc_top_inst (
    .mclk_in                 (mclk_in),
    .nrst_in                 (nrst_in),
    .ce_in                   (ce_in),
    .reg_addr_in             (reg_addr_in),
    .reg_wr_in               (reg_wr_in),
    .reg_rd_in               (reg_rd_in),
    .reg_wdata_in            (reg_wdata_in),
    .averaged_coil_sample_in (averaged_coil_sample_in),
    .sample_valid_in         (sample_valid_in),
    .reg_rdata_out           (reg_rdata_out),
    .reg_rvalid_out          (reg_rvalid_out),
    .reg_hit_out             (reg_hit_out),
    .low_threshold_a_out     (low_threshold_a_out),
    .high_threshold_out      (high_threshold_out),
    .below_low_a_flag_out    (below_low_a_flag_out),
    .above_high_flag_out     (above_high_flag_out)
  );
  cvlc_host cvlc_host_inst (.mclk_in(mclk_in), .rdata_in(reg_rdata_out), .rvalid_in(reg_rvalid_out),
    .hit_in(reg_hit_out), .addr_out(reg_addr_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
    .wdata_out(reg_wdata_in));
  always #50 mclk_in = ~mclk_in;
  // Read and compare; parity makes the whole word odd
  task automatic rd_chk(input logic [7:0] a, input logic [9:0] t, input logic h);
    logic [15:0] d;
    logic        hv, v;
    cvlc_host_inst.rd_reg(a, d, hv, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("hit", h, hv)
    `CHK("word", h ? {5'h00, t, ~^t} : 16'h0000, d)
  endtask
  task automatic smp(input logic [9:0] s, input logic c);
    @(negedge mclk_in);
    averaged_coil_sample_in = s;
    sample_valid_in = 1'b1;
    ce_in = c;
    @(negedge mclk_in);
    sample_valid_in = 1'b0;
    ce_in = 1'b1;
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // About 45 cycles of tests; give about 800 cycles
  initial
  begin
    #80000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    mclk_in = 1'b0;
    nrst_in = 1'b0;
    ce_in = 1'b1;
    sample_valid_in = 1'b0;
    averaged_coil_sample_in = 10'h000;
    repeat (4) @(posedge mclk_in);
    @(negedge mclk_in);
    nrst_in = 1'b1;
    rd_chk(LOW_LIMIT_A_ADDR, 10'h000, 1'b1);
    rd_chk(UPPER_LIMIT_ADDR, 10'h3ff, 1'b1);
    rd_chk(8'h10, 10'h000, 1'b0);
    smp(10'h3ff, 1'b1);
    `CHK("above", 1'b0, above_high_flag_out)
    $display("test reset done");
    cvlc_host_inst.wr_reg(LOW_LIMIT_A_ADDR, 16'hfa01);
    cvlc_host_inst.wr_reg(UPPER_LIMIT_ADDR, 16'hfc01);
    cvlc_host_inst.wr_reg(8'h10, 16'h0002);
    rd_chk(LOW_LIMIT_A_ADDR, 10'h100, 1'b1);
    rd_chk(UPPER_LIMIT_ADDR, 10'h200, 1'b1);
    `CHK("low_thr", 10'h100, low_threshold_a_out)
    `CHK("high_thr", 10'h200, high_threshold_out)
    $display("test registers done");
    foreach (smpl[i])
    begin
      smp(smpl[i], 1'b1);
      `CHK("below", smpl[i] < 10'h100, below_low_a_flag_out)
      `CHK("above", smpl[i] > 10'h200, above_high_flag_out)
    end
    averaged_coil_sample_in = 10'h3ff;
    repeat (3) @(negedge mclk_in);
    `CHK("below", 1'b1, below_low_a_flag_out)
    smp(10'h3ff, 1'b0);
    `CHK("above", 1'b0, above_high_flag_out)
    `CHK("below", 1'b1, below_low_a_flag_out)
    $display("test flags done");
    nrst_in = 1'b0;
    @(negedge mclk_in);
    `CHK("below", 1'b0, below_low_a_flag_out)
    `CHK("low_thr", 10'h000, low_threshold_a_out)
    `CHK("high_thr", 10'h3ff, high_threshold_out)
    nrst_in = 1'b1;
    rd_chk(LOW_LIMIT_A_ADDR, 10'h000, 1'b1);
    rd_chk(UPPER_LIMIT_ADDR, 10'h3ff, 1'b1);
    $display("test midrun reset done");
    wrap_up();
  end
endmodule
bind cvlc_top cvlc_assertions cvlc_assertions_inst (.mclk_in, .nrst_in, .ce_in,
  .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .averaged_coil_sample_in,
  .sample_valid_in, .reg_rdata_out, .reg_rvalid_out, .reg_hit_out, .low_threshold_a_out,
  .high_threshold_out, .below_low_a_flag_out, .above_high_flag_out);
